// File: rtl/qetc_ctrl.sv
// encoder interface control: timer prescale, clock and direction source, index reset
// assumes pins are already synchronous to clk and the quadrature decoder lives elsewhere
//
// Overview of operation
// R1: the timer input clock is divided by 256, 64, 8 or 1 for prescale codes 11, 10, 01, 00.
// R2: with index reset enabled an index pulse clears the position count, otherwise it does not.
// R3: index reset enable only acts while the mode field is 100 or 110.
// R4: with timer source select set the counter is clocked by rising edges of phase A.
// R5: with timer source select clear the counter is clocked by the internal cycle clock.
// R6: with direction source select set the counting direction is the phase B level.
// R7: with direction source select clear the direction is the writable control bit 11.
// R8: in quadrature modes gate, prescale, timer source and direction source are ignored; the code still drives count_direction from direction source.
// R9: in timer use the count steps by one in the chosen direction at each prescaler terminal.
//
// The plain strobed port and the register offsets were decided locally.
`timescale 1ns/10ps
module qetc_ctrl (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_b,
	// register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic [15:0]      reg_rdata,
	// encoder pins
	input  wire logic        phase_a_input,
	input  wire logic        phase_b_input,
	input  wire logic        index_input,
	// status
	output logic [15:0]      position_count,
	output logic             count_direction
);
	logic [15:0] control_q;
	logic [15:0] position_q;
	logic [15:0] position_d;
	logic [15:0] rdata_q;
	logic        phase_a_q;
	logic        index_q;
	logic        a_rise;
	logic        index_rise;
	logic        timer_mode;
	logic        index_mode;
	logic        src_tick;
	logic        step;
	logic        dir_up;
	logic        wr_ctrl;
	logic        wr_pos;
	logic [2:0]  mode;

	assign mode       = control_q[qetc_pkg::LSB_MODE +: 3];
	assign timer_mode = (mode == qetc_pkg::QETC_MODE_TIMER);
	assign index_mode = (mode == qetc_pkg::QETC_MODE_X2_INDEX)
		|| (mode == qetc_pkg::QETC_MODE_X4_INDEX); // see R3
	assign wr_ctrl    = reg_wr && (reg_addr == qetc_pkg::OFS_CONTROL);
	assign wr_pos     = reg_wr && (reg_addr == qetc_pkg::OFS_POSITION);
	assign a_rise     = phase_a_input && !phase_a_q;
	assign index_rise = index_input && !index_q;

	// source tick only exists in timer use, so quadrature modes ignore these bits
	assign src_tick = timer_mode && (control_q[qetc_pkg::BIT_TMR_SRC] ? a_rise // see R4
		: 1'b1); // see R5 R8

	// direction source; phase b level is used as it stands this cycle
	assign dir_up = control_q[qetc_pkg::BIT_DIR_SRC] ? phase_b_input // see R6
		: control_q[qetc_pkg::BIT_DIR_CTRL]; // see R7

	qetc_prescaler u_prescaler (
		.clk   (clk),
		.rst_b (rst_b),
		.clear (!timer_mode),
		.sel   (control_q[qetc_pkg::LSB_PRESCALE +: 2]),
		.tick  (src_tick),
		.term  (step)
	);

	// control register; bit 11 is read-only while a quadrature mode is selected
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			control_q <= qetc_pkg::CONTROL_RESET;
		end else if (wr_ctrl) begin
			control_q <= (reg_wdata & qetc_pkg::CONTROL_WMASK)
				| (mode[2] ? (control_q & ~qetc_pkg::CONTROL_WMASK) : 16'h0000);
			if (mode[2]) begin
				control_q[qetc_pkg::BIT_DIR_CTRL] <= control_q[qetc_pkg::BIT_DIR_CTRL];
			end
		end
	end

	// edge detectors on the pins
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			phase_a_q <= 1'b0;
			index_q   <= 1'b0;
		end else begin
			phase_a_q <= phase_a_input;
			index_q   <= index_input;
		end
	end

	// index reset beats a software write and a timer step in the same cycle
	always_comb begin
		position_d = position_q;
		if (index_mode && control_q[qetc_pkg::BIT_IDX_RST] && index_rise) begin
			position_d = qetc_pkg::POSITION_RESET; // see R2 R3
		end else if (wr_pos) begin
			position_d = reg_wdata;
		end else if (step) begin
			position_d = dir_up ? position_q + 16'h0001 : position_q - 16'h0001; // see R9
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			position_q <= qetc_pkg::POSITION_RESET;
		end else begin
			position_q <= position_d;
		end
	end

	// read data valid in the cycle after the strobe only
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rdata_q <= 16'h0000;
		end else if (reg_rd && reg_addr == qetc_pkg::OFS_CONTROL) begin
			rdata_q <= control_q;
			rdata_q[qetc_pkg::BIT_INDEX_PIN] <= index_input;
		end else if (reg_rd && reg_addr == qetc_pkg::OFS_POSITION) begin
			rdata_q <= position_q;
		end else begin
			rdata_q <= 16'h0000;
		end
	end

	assign reg_rdata       = rdata_q;
	assign position_count  = position_q;
	assign count_direction = dir_up;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	logic idx_arm;
	assign idx_arm = control_q[qetc_pkg::BIT_IDX_RST] && index_rise && !reg_wr;

	sequence s_int_up;
		timer_mode && !reg_wr && control_q[4:0] == 5'b00000
			&& control_q[qetc_pkg::BIT_DIR_CTRL];
	endsequence

	sequence s_int_down;
		timer_mode && !reg_wr && control_q[4:0] == 5'b00000
			&& !control_q[qetc_pkg::BIT_DIR_CTRL];
	endsequence

	// cycles since the last step; any control write restarts it, so a spacing
	// is only judged between two steps taken under one unchanged setting
	logic [8:0] gap_q;
	logic       gap_ok_q;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			gap_q    <= 9'h000;
			gap_ok_q <= 1'b0;
		end else if (wr_ctrl) begin
			gap_q    <= 9'h000;
			gap_ok_q <= 1'b0;
		end else if (step) begin
			gap_q    <= 9'h000;
			gap_ok_q <= 1'b1;
		end else if (gap_q != 9'h1ff) begin
			gap_q <= gap_q + 9'h001;
		end
	end

	sequence s_div64_step;
		step && gap_ok_q && !reg_wr && control_q[4:0] == 5'b10000;
	endsequence

	chk_index_clears_count: assert property ( // see R2
		idx_arm && index_mode |=> position_q == 16'h0000)
		else $error("index pulse did not clear the position count");
	chk_index_other_mode: assert property ( // see R3
		idx_arm && mode == qetc_pkg::QETC_MODE_X2_MATCH |=> $stable(position_q))
		else $error("index pulse acted outside the index reset modes");
	chk_index_disabled: assert property ( // see R2
		index_mode && !control_q[qetc_pkg::BIT_IDX_RST] && !reg_wr |=> $stable(position_q))
		else $error("index pulse acted with index reset disabled");
	chk_internal_up: assert property ( // see R5
		s_int_up |=> position_q == $past(position_q) + 16'h0001)
		else $error("internal clock did not count up every cycle");
	chk_phase_b_dir: assert property ( // see R6
		timer_mode && !reg_wr && control_q[4:0] == 5'b00001 && !phase_b_input
		|=> position_q == $past(position_q) - 16'h0001)
		else $error("phase b low did not count down");
	chk_ext_no_edge: assert property ( // see R4
		timer_mode && !reg_wr && control_q[qetc_pkg::BIT_TMR_SRC] && !a_rise
		|=> $stable(position_q))
		else $error("counter moved without a phase a rising edge");
	chk_ext_edge_step: assert property ( // see R4
		timer_mode && !reg_wr && control_q[4:0] == 5'b00010
			&& control_q[qetc_pkg::BIT_DIR_CTRL] && a_rise
		|=> position_q == $past(position_q) + 16'h0001)
		else $error("phase a rising edge did not step the count");
	chk_prescale_eight: assert property ( // see R1
		step && timer_mode && control_q[4:0] == 5'b01000 && !reg_wr
		|=> !step [*7])
		else $error("divide by eight stepped too soon");
	// apart from a position write, only an armed index pulse may move the count while a quadrature mode is set
	chk_quad_hold: assert property ( // see R8
		mode[2] && !reg_wr && !(control_q[qetc_pkg::BIT_IDX_RST] && index_rise)
		|=> $stable(position_q))
		else $error("timer settings moved the count in a quadrature mode");
	chk_internal_down: assert property ( // see R7
		s_int_down |=> position_q == $past(position_q) - 16'h0001)
		else $error("direction bit clear did not count down");
	chk_phase_b_up: assert property ( // see R6
		timer_mode && !reg_wr && control_q[4:0] == 5'b00001 && phase_b_input
		|=> position_q == $past(position_q) + 16'h0001)
		else $error("phase b high did not count up");
	chk_prescale_sixty_four: assert property ( // see R1
		s_div64_step |-> gap_q == {1'b0, qetc_pkg::LIM_DIV64})
		else $error("divide by sixty four stepped at the wrong spacing");
	chk_dir_bit_locked: assert property ( // see R7
		wr_ctrl && mode[2] |=> $stable(control_q[qetc_pkg::BIT_DIR_CTRL]))
		else $error("direction bit changed by a write in a quadrature mode");
endmodule

// File: rtl/qetc_pkg.sv
// constants shared by the encoder timer/clock/direction control block
// assumes a 16-bit register port with byte addresses
package qetc_pkg;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 16;

	// register offsets
	localparam logic [7:0] OFS_CONTROL  = 8'h00;
	localparam logic [7:0] OFS_POSITION = 8'h04;

	// control register field positions
	localparam int unsigned BIT_DIR_SRC   = 0;
	localparam int unsigned BIT_TMR_SRC   = 1;
	localparam int unsigned BIT_IDX_RST   = 2;
	localparam int unsigned LSB_PRESCALE  = 3;
	localparam int unsigned BIT_GATE      = 5;
	localparam int unsigned BIT_DIR_OUTEN = 6;
	localparam int unsigned BIT_SWAP      = 7;
	localparam int unsigned LSB_MODE      = 8;
	localparam int unsigned BIT_DIR_CTRL  = 11;
	localparam int unsigned BIT_INDEX_PIN = 12;
	localparam int unsigned BIT_IDLE_STOP = 13;

	localparam logic [15:0] CONTROL_RESET = 16'h0000;
	localparam logic [15:0] CONTROL_WMASK = 16'h2fff;
	localparam logic [15:0] POSITION_RESET = 16'h0000;

	// interface mode field codes
	typedef enum logic [2:0] {
		QETC_MODE_OFF      = 3'b000,
		QETC_MODE_TIMER    = 3'b001,
		QETC_MODE_UNUSED2  = 3'b010,
		QETC_MODE_UNUSED3  = 3'b011,
		QETC_MODE_X2_INDEX = 3'b100,
		QETC_MODE_X2_MATCH = 3'b101,
		QETC_MODE_X4_INDEX = 3'b110,
		QETC_MODE_X4_MATCH = 3'b111
	} qetc_mode_e;

	// prescale codes and their terminal counts (divide minus one)
	localparam logic [1:0] PS_DIV1   = 2'b00;
	localparam logic [1:0] PS_DIV8   = 2'b01;
	localparam logic [1:0] PS_DIV64  = 2'b10;
	localparam logic [1:0] PS_DIV256 = 2'b11;
	localparam logic [7:0] LIM_DIV1   = 8'h00;
	localparam logic [7:0] LIM_DIV8   = 8'h07;
	localparam logic [7:0] LIM_DIV64  = 8'h3f;
	localparam logic [7:0] LIM_DIV256 = 8'hff;

	function automatic logic [7:0] ps_limit(input logic [1:0] sel);
		case (sel)
			PS_DIV8:   ps_limit = LIM_DIV8;
			PS_DIV64:  ps_limit = LIM_DIV64;
			PS_DIV256: ps_limit = LIM_DIV256;
			default:   ps_limit = LIM_DIV1;
		endcase
	endfunction
endpackage

// File: rtl/qetc_prescaler.sv
// timer input prescaler: one terminal pulse per 1, 8, 64 or 256 source ticks
// assumes tick is a one-cycle enable in the clk domain
`timescale 1ns/10ps
module qetc_prescaler (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst_b,
	// control
	input  wire logic       clear,
	input  wire logic [1:0] sel,
	input  wire logic       tick,
	// result
	output logic            term
);
	logic [7:0] count_q;

	// divide by 1 passes every tick straight through
	assign term = tick && (count_q >= qetc_pkg::ps_limit(sel)); // see R1

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			count_q <= 8'h00;
		end else if (clear || term) begin
			count_q <= 8'h00;
		end else if (tick) begin
			count_q <= count_q + 8'h01; // see R1
		end
	end
endmodule

// File: verif/encoder_timer_clock_dir_ctrl_tb_top.sv
// self-checking bench for the encoder timer clock and direction control
// assumes qetc_pkg, qetc_prescaler and qetc_ctrl are compiled first
`timescale 1ns/10ps
module encoder_timer_clock_dir_ctrl_tb_top;
	typedef struct {logic [15:0] ctrl; logic b; logic run; int per;
		logic [15:0] dlt; logic dir;} qetc_row_s;
	logic        clk, rst_b, reg_wr, reg_rd, a_run, b_lvl, idx_lvl, pa, pb, ix, cdir;
	logic [7:0]  reg_addr;
	logic [15:0] reg_wdata, reg_rdata, pos, p0;
	logic [31:0] idx [5];
	int          miscompares, total_checks, per, n;
	qetc_row_s   rows [9];
	qetc_ctrl u_qetc_ctrl (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .phase_a_input(pa),
		.phase_b_input(pb), .index_input(ix), .position_count(pos), .count_direction(cdir));
	qetc_enc_model u_qetc_enc_model (.clk(clk), .rst_b(rst_b), .a_run(a_run), .b_lvl(b_lvl),
		.idx_lvl(idx_lvl), .phase_a(pa), .phase_b(pb), .index_pin(ix));
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		@(posedge clk);
		reg_wr <= 1'h0;
	endtask
	// read data must stand for exactly the one cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [15:0] exp);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge clk);
		reg_rd <= 1'h0;
		#1 chk(reg_rdata, exp);
		@(posedge clk);
		#1 chk(reg_rdata, 16'h0000);
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	initial begin
		clk = 1'h0;
		forever #2.5 clk = ~clk;
	end
	// whole run needs well under 20k cycles
	initial begin
		#400us;
		miscompares++;
		conclude();
	end
	initial begin
		{rst_b, reg_wr, reg_rd, a_run, b_lvl, idx_lvl} = 6'h0;
		reg_addr = 8'h00;
		reg_wdata = 16'h0000;
		miscompares = 0;
		total_checks = 0;
		rows = '{'{16'h0900, 1'h0, 1'h0, 1, 16'h0001, 1'h1},
			'{16'h0908, 1'h0, 1'h0, 8, 16'h0001, 1'h1},
			'{16'h0910, 1'h0, 1'h0, 64, 16'h0001, 1'h1},
			'{16'h0918, 1'h0, 1'h0, 256, 16'h0001, 1'h1},
			'{16'h0100, 1'h0, 1'h0, 1, 16'hffff, 1'h0},
			'{16'h0101, 1'h1, 1'h0, 1, 16'h0001, 1'h1},
			'{16'h0901, 1'h0, 1'h0, 1, 16'hffff, 1'h0},
			'{16'h0902, 1'h0, 1'h1, 4, 16'h0001, 1'h1},
			'{16'h090a, 1'h0, 1'h1, 32, 16'h0001, 1'h1}};
		idx = '{32'h0404_0000, 32'h0604_0000, 32'h0400_1234, 32'h0504_1234, 32'h041b_1234};
		repeat (15) @(posedge clk);
		#1 chk(pos, qetc_pkg::POSITION_RESET);
		chk({15'h0000, cdir}, 16'h0000);
		@(posedge clk);
		rst_b <= 1'h1;
		rd(qetc_pkg::OFS_CONTROL, qetc_pkg::CONTROL_RESET);
		rd(qetc_pkg::OFS_POSITION, qetc_pkg::POSITION_RESET);
		foreach (rows[i]) begin
			wr(qetc_pkg::OFS_CONTROL, 16'h0000);
			a_run <= rows[i].run;
			b_lvl <= rows[i].b;
			wr(qetc_pkg::OFS_POSITION, 16'h0000);
			wr(qetc_pkg::OFS_CONTROL, rows[i].ctrl);
			#1 chk({15'h0000, cdir}, {15'h0000, rows[i].dir});
			n = 0;
			while (pos === 16'h0000 && n < 1000) begin
				@(posedge clk);
				#1 n++;
			end
			p0 = pos;
			per = 0;
			while (pos === p0 && per < 1000) begin
				@(posedge clk);
				#1 per++;
			end
			chk(per[15:0], rows[i].per[15:0]);
			chk(pos - p0, rows[i].dlt);
		end
		// phase a keeps toggling so the quadrature modes must ignore the timer source
		a_run <= 1'h1;
		foreach (idx[i]) begin
			wr(qetc_pkg::OFS_CONTROL, idx[i][31:16]);
			wr(qetc_pkg::OFS_POSITION, 16'h1234);
			idx_lvl <= 1'h1;
			repeat (4) @(posedge clk);
			idx_lvl <= 1'h0;
			rd(qetc_pkg::OFS_POSITION, idx[i][15:0]);
		end
		// top two bits are unimplemented and an unmapped write must change nothing
		wr(qetc_pkg::OFS_CONTROL, 16'hc0ff);
		wr(8'h02, 16'hffff);
		rd(qetc_pkg::OFS_CONTROL, 16'h00ff);
		rd(8'h02, 16'h0000);
		// direction bit is writable in mode 000 and frozen once a quadrature mode is set
		wr(qetc_pkg::OFS_CONTROL, 16'h0c00);
		wr(qetc_pkg::OFS_CONTROL, 16'h0400);
		rd(qetc_pkg::OFS_CONTROL, 16'h0c00);
		// reset in mid-run, with the timer counting, must drop count and control at once
		wr(qetc_pkg::OFS_CONTROL, 16'h0900);
		repeat (8) @(posedge clk);
		rst_b <= 1'h0;
		@(posedge clk);
		#1 chk(pos, qetc_pkg::POSITION_RESET);
		chk({15'h0000, cdir}, 16'h0000);
		@(posedge clk);
		rst_b <= 1'h1;
		rd(qetc_pkg::OFS_CONTROL, qetc_pkg::CONTROL_RESET);
		rd(qetc_pkg::OFS_POSITION, qetc_pkg::POSITION_RESET);
		conclude();
	end
endmodule

// File: verif/qetc_enc_model.sv
// encoder stand-in: phase A square wave on demand, phase B and index levels
// assumes the bench steers it from the clk domain
`timescale 1ns/10ps
module qetc_enc_model (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_b,
	// steering
	input  wire logic a_run,
	input  wire logic b_lvl,
	input  wire logic idx_lvl,
	// encoder outputs
	output logic      phase_a,
	output logic      phase_b,
	output logic      index_pin
);
	logic half_q;
	// levels change only on clk, so the block sees them as synchronous pins
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			{half_q, phase_a, phase_b, index_pin} <= 4'h0;
		end else begin
			half_q <= ~half_q;
			if (a_run && half_q) begin
				phase_a <= ~phase_a;
			end
			phase_b <= b_lvl;
			index_pin <= idx_lvl;
		end
	end
endmodule
